/* cdp_datapath.sv */
// Purpose: 16-bit datapath, bus b/c selection, alu, working registers, status flags
// Assumes: microcode drives strobes; bit 0 is the msb (stored in vector bit 15)
// Notes: registers reached over AXI4-Lite; write to ctrl pulses microcode strobes
// Behaviour
// (RULE1) bus b picks one of four sources
// (RULE2) bus c swaps bytes or shifts one bit
// (RULE3) code 011 passes bits, ends from fill
// (RULE4) alu: sixteen logic, sixteen arithmetic functions
// (RULE5) a plus a shifts left
// (RULE6) pointer increments or loads alu output
// (RULE7) save register captures pointer on strobe
// (RULE8) instruction register loads memory data
// (RULE9) accumulator increments or loads bus c
// (RULE10) extension word loads and shifts
// (RULE11) base, link, maintenance load under microcode
// (RULE12) storage scratch loads or increments
// (RULE13) index register loads or increments
// (RULE14) compare flags capture on enabled clock
// (RULE15) aux port may write compare, overflow
// (RULE16) overflow set or cleared by overflowing ops
// (RULE17) carry follows carry into sign bit
// (RULE18) carry is xor of a0, b0, alu0
// (RULE19) aux start may set carry
// (RULE20) protection violation raises internal interrupt
// (RULE21) protect flag loads alu bit 4, gated
// (RULE22) violation flag set by signal, cleared
// (RULE23) all state updates on clock edges
`timescale 1ns/100ps
`default_nettype none
module cdp_datapath
    import cdp_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        clk_en,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        addr_violation_signal_n,
    input  wire logic        interrupt_active,
    input  wire logic        fetch_cycle,
    output logic             protect_to_memctl_ff,
    output logic             internal_irq_ff
);
    logic       aviol_meta_ff, aviol_sync_ff;
    logic       irq_meta_ff, irq_sync_ff, fetch_meta_ff, fetch_sync_ff;
    cdp_alu_ctl_type alu_ctl_ff;
    logic [1:0] bsel_ff;
    logic [2:0] csel_ff;
    logic       left_shift_fill_ff, right_shift_fill_ff, nonshift_end_bit_ff;
    logic       single_step_mode_ff, cmp_sel_ff;
    logic [15:0] bus_a_ff;
    logic [15:0] memory_address_latch_ff, utility_temp_ff, read_data_latch_ff;
    logic [15:0] mem_data_ff;
    cdp_strobe_type strobe;
    logic        status_clear, aux_wr, aux_processor_start;
    logic [15:0] aux_word;
    logic [15:0] instr_pointer_ff, instr_pointer_save_ff, current_instruction_ff;
    logic [15:0] accumulator_ff, extension_word_ff, base_reg_ff, link_word_ff;
    logic [15:0] maint_scratch_ff, storage_scratch_ff, index_reg_ff;
    logic compare_flag_hi_ff, compare_flag_lo_ff, overflow_flag_ff, carry_flag_ff;
    logic protect_enable_ff, address_violation_flag_ff;
    logic [15:0] bus_b, alu_f, bus_c;
    logic        carry_cond, ovf_cond, privilege_protect;
    // msb-first bit access: bit n of the word is vector bit 15-n
    function automatic logic bitn(input logic [15:0] v, input int n);
        return v[15-n];
    endfunction

    function automatic logic [15:0] alu_fn(input cdp_alu_ctl_type c,
                                           input logic [15:0] a, input logic [15:0] b);
        logic [15:0] r;
        logic [15:0] ci;
        ci = {15'h0000, c.carry_in};
        if (c.mode) begin // RULE4
            case (c.func)
                4'h0: r = ~a;
                4'h1: r = ~(a | b);
                4'h2: r = ~a & b;
                4'h3: r = 16'h0000;
                4'h4: r = ~(a & b);
                4'h5: r = ~b;
                4'h6: r = a ^ b;
                4'h7: r = a & ~b;
                4'h8: r = ~a | b;
                4'h9: r = ~(a ^ b);
                4'ha: r = b;
                4'hb: r = a & b;
                4'hc: r = 16'hffff;
                4'hd: r = a | ~b;
                4'he: r = a | b;
                default: r = a;
            endcase
        end else begin // RULE4
            case (c.func)
                4'h0: r = a + ci;
                4'h1: r = (a | b) + ci;
                4'h2: r = (a | ~b) + ci;
                4'h3: r = 16'hffff + ci;
                4'h4: r = a + (a & ~b) + ci;
                4'h5: r = (a | b) + (a & ~b) + ci;
                4'h6: r = a - b - 16'h0001 + ci;
                4'h7: r = (a & ~b) - 16'h0001 + ci;
                4'h8: r = a + (a & b) + ci;
                4'h9: r = a + b + ci;
                4'ha: r = (a | ~b) + (a & b) + ci;
                4'hb: r = (a & b) - 16'h0001 + ci;
                4'hc: r = {a[14:0], 1'b0} + ci; // RULE5
                4'hd: r = (a | b) + a + ci;
                4'he: r = (a | ~b) + a + ci;
                default: r = a - 16'h0001 + ci;
            endcase
        end
        return r;
    endfunction
    // datapath
    always_comb begin
        case (bsel_ff) // RULE1
            BSEL_MAL: bus_b = memory_address_latch_ff;
            BSEL_UT:  bus_b = utility_temp_ff;
            BSEL_RDL: bus_b = read_data_latch_ff;
            BSEL_CI:  bus_b = current_instruction_ff;
            default:  bus_b = memory_address_latch_ff;
        endcase
    end
    assign alu_f = alu_fn(alu_ctl_ff, bus_a_ff, bus_b);
    always_comb begin
        case (csel_ff)
            CSEL_SWAP: bus_c = {alu_f[7:0], alu_f[15:8]}; // RULE2
            CSEL_LSH:  bus_c = {left_shift_fill_ff, alu_f[13:0], left_shift_fill_ff}; // RULE2
            CSEL_RSH:  bus_c = {right_shift_fill_ff, alu_f[15:1]}; // RULE2
            CSEL_PASS: bus_c = {nonshift_end_bit_ff, alu_f[14:1], nonshift_end_bit_ff}; // RULE3
            default:   bus_c = alu_f;
        endcase
    end
    assign carry_cond = bitn(bus_a_ff, 0) ^ bitn(bus_b, 0) ^ bitn(alu_f, 0); // RULE18
    assign ovf_cond   = (bitn(bus_a_ff, 0) ^ bitn(alu_f, 0));
    assign privilege_protect = protect_enable_ff;
    // synchronisers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aviol_meta_ff <= 1'b0;
            aviol_sync_ff <= 1'b0;
            irq_meta_ff   <= 1'b0;
            irq_sync_ff   <= 1'b0;
            fetch_meta_ff <= 1'b0;
            fetch_sync_ff <= 1'b0;
        end else if (clk_en) begin
            aviol_meta_ff <= ~addr_violation_signal_n;
            aviol_sync_ff <= aviol_meta_ff;
            irq_meta_ff   <= interrupt_active;
            irq_sync_ff   <= irq_meta_ff;
            fetch_meta_ff <= fetch_cycle;
            fetch_sync_ff <= fetch_meta_ff;
        end
    end
    // axi4-lite slave
    logic        aw_have_ff, w_have_ff;
    logic [7:0]  aw_addr_ff;
    logic [31:0] w_data_ff;
    logic        do_write;
    assign do_write = aw_have_ff && w_have_ff && !s_axi_bvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_ff    <= 1'b0;
            w_have_ff     <= 1'b0;
            aw_addr_ff    <= 8'h00;
            w_data_ff     <= 32'h00000000;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
        end else if (clk_en) begin
            s_axi_awready <= !aw_have_ff && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !w_have_ff && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_ff <= 1'b1;
                aw_addr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_ff <= 1'b1;
                w_data_ff <= s_axi_wdata;
            end
            if (do_write) begin
                aw_have_ff   <= 1'b0;
                w_have_ff    <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (aw_addr_ff <= OFS_AUX && aw_addr_ff[1:0] == 2'h0)
                                ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    // write decode: ctrl strobes pulse for one cycle
    always_comb begin
        strobe = '0;
        status_clear = 1'b0;
        aux_wr = 1'b0;
        aux_processor_start = 1'b0;
        aux_word = w_data_ff[15:0];
        if (do_write && aw_addr_ff == OFS_CTRL) begin
            strobe = w_data_ff[20:0];
            status_clear = w_data_ff[21];
        end
        if (do_write && aw_addr_ff == OFS_AUX) begin
            aux_wr = w_data_ff[16];
            aux_processor_start = w_data_ff[17];
        end
    end
    // busc config register and source latches
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            alu_ctl_ff <= '0;
            bsel_ff <= BSEL_MAL;
            csel_ff <= CSEL_PASS;
            left_shift_fill_ff <= 1'b0;
            right_shift_fill_ff <= 1'b0;
            nonshift_end_bit_ff <= 1'b0;
            single_step_mode_ff <= 1'b0;
            cmp_sel_ff <= 1'b0;
            bus_a_ff <= WORD_RESET;
            memory_address_latch_ff <= WORD_RESET;
            utility_temp_ff <= WORD_RESET;
            read_data_latch_ff <= WORD_RESET;
            mem_data_ff <= WORD_RESET;
        end else if (clk_en && do_write && aw_addr_ff == OFS_BUSC) begin
            case (w_data_ff[31:28])
                4'h0: begin
                    alu_ctl_ff <= w_data_ff[5:0];
                    bsel_ff <= w_data_ff[7:6];
                    csel_ff <= w_data_ff[10:8];
                    left_shift_fill_ff <= w_data_ff[11];
                    right_shift_fill_ff <= w_data_ff[12];
                    nonshift_end_bit_ff <= w_data_ff[13];
                    single_step_mode_ff <= w_data_ff[14];
                    cmp_sel_ff <= w_data_ff[15];
                end
                4'h1: bus_a_ff <= w_data_ff[15:0];
                4'h2: memory_address_latch_ff <= w_data_ff[15:0];
                4'h3: utility_temp_ff <= w_data_ff[15:0];
                4'h4: read_data_latch_ff <= w_data_ff[15:0];
                4'h5: mem_data_ff <= w_data_ff[15:0];
                default: ;
            endcase
        end
    end
    // working registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            instr_pointer_ff <= WORD_RESET;
            instr_pointer_save_ff <= WORD_RESET;
            current_instruction_ff <= WORD_RESET;
            accumulator_ff <= WORD_RESET;
            extension_word_ff <= WORD_RESET;
            base_reg_ff <= WORD_RESET;
            link_word_ff <= WORD_RESET;
            maint_scratch_ff <= WORD_RESET;
            storage_scratch_ff <= WORD_RESET;
            index_reg_ff <= WORD_RESET;
        end else if (clk_en) begin // RULE23
            if (strobe.ip_load || strobe.rr_names_ip) instr_pointer_ff <= alu_f; // RULE6
            else if (strobe.ip_inc) instr_pointer_ff <= instr_pointer_ff + 16'h0001; // RULE6
            if (strobe.ips_clk) instr_pointer_save_ff <= instr_pointer_ff; // RULE7
            if (strobe.ci_strobe) current_instruction_ff <= mem_data_ff; // RULE8
            if (strobe.acc_load) accumulator_ff <= bus_c; // RULE9
            else if (strobe.acc_inc) accumulator_ff <= accumulator_ff + 16'h0001; // RULE9
            if (strobe.ext_load) extension_word_ff <= bus_c; // RULE10
            else if (strobe.ext_shl) // RULE10
                extension_word_ff <= {extension_word_ff[14:0], right_shift_fill_ff};
            else if (strobe.ext_shr) // RULE10
                extension_word_ff <= {left_shift_fill_ff, extension_word_ff[15:1]};
            if (strobe.base_load) base_reg_ff <= bus_c; // RULE11
            if (strobe.link_load) link_word_ff <= bus_c; // RULE11
            if (strobe.maint_load) maint_scratch_ff <= bus_c; // RULE11
            if (strobe.stor_load) storage_scratch_ff <= bus_c; // RULE12
            else if (strobe.stor_inc) storage_scratch_ff <= storage_scratch_ff + 16'h0001; // RULE12
            if (strobe.index_load) index_reg_ff <= bus_c; // RULE13
            else if (strobe.index_inc) index_reg_ff <= index_reg_ff + 16'h0001; // RULE13
        end
    end
    // status flags
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {compare_flag_hi_ff, compare_flag_lo_ff, overflow_flag_ff, carry_flag_ff,
             protect_enable_ff, address_violation_flag_ff} <= STATUS_RESET;
            protect_to_memctl_ff <= 1'b0;
            internal_irq_ff <= 1'b0;
        end else if (clk_en) begin
            if (aux_wr) begin // RULE15
                compare_flag_hi_ff <= aux_word[1];
                compare_flag_lo_ff <= aux_word[0];
                overflow_flag_ff <= aux_word[2];
            end else if (strobe.cmp_clk) begin // RULE14
                compare_flag_hi_ff <= (bus_a_ff > bus_b);
                compare_flag_lo_ff <= (cmp_sel_ff ? (bus_a_ff == bus_c) : (bus_a_ff == bus_b))
                                      && !(bus_a_ff > bus_b);
            end
            if (!aux_wr && strobe.ovf_clk) overflow_flag_ff <= ovf_cond; // RULE16
            if (aux_processor_start) carry_flag_ff <= aux_word[3]; // RULE19
            else if (strobe.carry_clk) carry_flag_ff <= carry_cond; // RULE17
            if (strobe.prot_clk) protect_enable_ff <= bitn(alu_f, 4); // RULE21
            if (aviol_sync_ff && protect_enable_ff) address_violation_flag_ff <= 1'b1; // RULE22
            else if (status_clear) address_violation_flag_ff <= 1'b0; // RULE22
            protect_to_memctl_ff <= privilege_protect && !irq_sync_ff
                                    && !(single_step_mode_ff && fetch_sync_ff); // RULE21
            internal_irq_ff <= privilege_protect && aviol_sync_ff; // RULE20
        end
    end
    // read channel
    logic [15:0] status_word;
    logic [15:0] rd_word;
    always_comb begin
        status_word = 16'h0000;
        status_word[ST_CMP_HI -: 6] = {compare_flag_hi_ff, compare_flag_lo_ff, overflow_flag_ff,
                                       carry_flag_ff, protect_enable_ff, address_violation_flag_ff};
        case (s_axi_araddr)
            OFS_STATUS: rd_word = status_word;
            OFS_ACC:   rd_word = accumulator_ff;
            OFS_EXT:   rd_word = extension_word_ff;
            OFS_IP:    rd_word = instr_pointer_ff;
            OFS_IPS:   rd_word = instr_pointer_save_ff;
            OFS_CI:    rd_word = current_instruction_ff;
            OFS_BASE:  rd_word = base_reg_ff;
            OFS_LINK:  rd_word = link_word_ff;
            OFS_MAINT: rd_word = maint_scratch_ff;
            OFS_STOR:  rd_word = storage_scratch_ff;
            OFS_INDEX: rd_word = index_reg_ff;
            OFS_BUSC:  rd_word = bus_c;
            default:   rd_word = 16'h0000;
        endcase
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= RESP_OKAY;
        end else if (clk_en) begin
            s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= {16'h0000, rd_word};
                s_axi_rresp  <= (s_axi_araddr <= OFS_AUX && s_axi_araddr[1:0] == 2'h0)
                                ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

/* cdp_memctl_model.sv */
// Purpose: memory controller side model
// Assumes: requests come from the bench
// Notes: violation line idles high
`timescale 1ns/100ps
`default_nettype none
module cdp_memctl_model (
    input wire logic aclk,
    input wire logic viol_req,
    input wire logic irq_req,
    output var logic addr_violation_signal_n = 1'b1,
    output var logic interrupt_active = 1'b0
);
    always @(posedge aclk) begin
        addr_violation_signal_n <= !viol_req;
        interrupt_active        <= irq_req;
    end
endmodule
`default_nettype wire

/* cdp_pkg.sv */
// Purpose: shared constants and types for the arithmetic datapath
// Assumes: 16-bit words, bit 0 is the most significant bit
// Notes: register offsets are byte addresses on the AXI4-Lite slave
package cdp_pkg;
    localparam int W = 16;
    // bus b select codes
    localparam logic [1:0] BSEL_MAL = 2'h0;
    localparam logic [1:0] BSEL_UT  = 2'h1;
    localparam logic [1:0] BSEL_RDL = 2'h2;
    localparam logic [1:0] BSEL_CI  = 2'h3;
    // bus c select codes
    localparam logic [2:0] CSEL_SWAP = 3'h0;
    localparam logic [2:0] CSEL_LSH  = 3'h1;
    localparam logic [2:0] CSEL_RSH  = 3'h2;
    localparam logic [2:0] CSEL_PASS = 3'h3;
    // register offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_ACC    = 8'h08;
    localparam logic [7:0] OFS_EXT    = 8'h0c;
    localparam logic [7:0] OFS_IP     = 8'h10;
    localparam logic [7:0] OFS_IPS    = 8'h14;
    localparam logic [7:0] OFS_CI     = 8'h18;
    localparam logic [7:0] OFS_BASE   = 8'h1c;
    localparam logic [7:0] OFS_LINK   = 8'h20;
    localparam logic [7:0] OFS_MAINT  = 8'h24;
    localparam logic [7:0] OFS_STOR   = 8'h28;
    localparam logic [7:0] OFS_INDEX  = 8'h2c;
    localparam logic [7:0] OFS_BUSC   = 8'h30;
    localparam logic [7:0] OFS_AUX    = 8'h34;
    // status field positions (vector bit index of a 16-bit word, 15 is the msb)
    localparam int ST_CMP_HI = 15;
    localparam int ST_CMP_LO = 14;
    localparam int ST_OVF    = 13;
    localparam int ST_CARRY  = 12;
    localparam int ST_PROT   = 11;
    localparam int ST_AVIOL  = 10;
    localparam logic [5:0]  STATUS_RESET = 6'h00;
    localparam logic [15:0] WORD_RESET   = 16'h0000;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;
    localparam logic [15:0] TRAP_ADDR    = 16'h0002;

    typedef struct packed {
        logic       mode;
        logic       carry_in;
        logic [3:0] func;
    } cdp_alu_ctl_type;

    typedef struct packed {
        logic ip_inc;
        logic ip_load;
        logic rr_names_ip;
        logic ips_clk;
        logic ci_strobe;
        logic acc_inc;
        logic acc_load;
        logic ext_load;
        logic ext_shr;
        logic ext_shl;
        logic base_load;
        logic link_load;
        logic maint_load;
        logic stor_load;
        logic stor_inc;
        logic index_load;
        logic index_inc;
        logic cmp_clk;
        logic ovf_clk;
        logic carry_clk;
        logic prot_clk;
    } cdp_strobe_type;
endpackage

/* cdp_properties.sv */
// Purpose: port checks for cdp_datapath
// Assumes: one clock, synchronous active-low reset
// Notes: bound into every cdp_datapath instance
`timescale 1ns/100ps
`default_nettype none
module cdp_properties
    import cdp_pkg::*;
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        addr_violation_signal_n,
    input wire logic        interrupt_active,
    input wire logic        protect_to_memctl_ff,
    input wire logic        internal_irq_ff
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    bvalid_holds_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped early");
    rvalid_holds_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("rvalid dropped early");
    awready_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
        else $error("awready longer than one cycle");
    wready_pulse_a: assert property (s_axi_wready |=> !s_axi_wready)
        else $error("wready longer than one cycle");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("no read answer one cycle after address");
    unmapped_read_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h34
        |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0)
        else $error("upper read bits not zero");
    protect_gate_a: assert property (interrupt_active [*4] |=> !protect_to_memctl_ff)
        else $error("protect copy not gated during interrupt");
    irq_cause_a: assert property ($rose(internal_irq_ff) |-> !$past(addr_violation_signal_n, 2)
        || !$past(addr_violation_signal_n, 3) || !$past(addr_violation_signal_n, 4))
        else $error("internal interrupt without violation");
endmodule
bind cdp_datapath cdp_properties u_props (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .addr_violation_signal_n(addr_violation_signal_n), .interrupt_active(interrupt_active),
    .protect_to_memctl_ff(protect_to_memctl_ff), .internal_irq_ff(internal_irq_ff));
`default_nettype wire

/* tb_cpu_datapath_status.sv */
// Purpose: self-checking bench for cdp_datapath
// Assumes: AXI4-Lite master tasks, memctl model
// Notes: clk_en held high, fetch_cycle low
`timescale 1ns/100ps
`default_nettype none
module tb_cpu_datapath_status;
    import cdp_pkg::*;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, viol_req, irq_req;
    logic        awready, wready, bvalid, arready, rvalid, prot_ff, irq_ff, viol_n, int_act;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [1:0]  bresp, rresp, r;
    int          err_total, compares;
    cdp_datapath dut (.aclk(aclk), .aresetn(aresetn), .clk_en(1'b1), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .addr_violation_signal_n(viol_n), .interrupt_active(int_act), .fetch_cycle(1'b0),
        .protect_to_memctl_ff(prot_ff), .internal_irq_ff(irq_ff));
    cdp_memctl_model u_mem (.aclk(aclk), .viol_req(viol_req), .irq_req(irq_req),
        .addr_violation_signal_n(viol_n), .interrupt_active(int_act));
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    task automatic complete_run();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic aw_ok, w_ok;
        {aw_ok, w_ok} = 2'b00;
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            aw_ok |= awready;
            w_ok |= wready;
            awvalid <= !aw_ok;
            wvalid <= !w_ok;
        end while (!(aw_ok && w_ok));
        bready <= 1'b1;
        do @(posedge aclk); while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    task automatic cfg(input logic [3:0] s, input logic [15:0] v);
        wr(OFS_BUSC, {s, 12'h0, v});
    endtask
    task automatic alu(input logic [2:0] cs, input logic [1:0] bs, input logic [5:0] f);
        cfg(4'h0, {5'h0, cs, bs, f});
    endtask
    task automatic st(input int b);
        wr(OFS_CTRL, 32'h1 << b);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [15:0] e);
        rd(a);
        chk(d, {16'h0, e});
    endtask
    task automatic t_reset();
        rchk(OFS_STATUS, 16'h0);
        chk({30'h0, prot_ff, irq_ff}, 32'h0);
    endtask
    task automatic t_busc();
        logic [15:0] v [3];
        cfg(4'h1, 16'h12c4);
        alu(CSEL_SWAP, BSEL_MAL, 6'h2f);
        rchk(OFS_BUSC, 16'hc412);
        alu(CSEL_SWAP, BSEL_MAL, 6'h0c);
        rchk(OFS_BUSC, 16'h8825);
        alu(CSEL_SWAP, BSEL_MAL, 6'h1c);
        rchk(OFS_BUSC, 16'h8925);
        v = '{16'h0310, 16'h5207, 16'h0a61};
        for (int k = 0; k < 3; k++) begin
            cfg(4'(k + 2), v[k]);
            alu(CSEL_SWAP, 2'(k), 6'h2a);
            rchk(OFS_BUSC, {v[k][7:0], v[k][15:8]});
        end
        alu(CSEL_SWAP, BSEL_MAL, 6'h16);
        rchk(OFS_BUSC, 16'hb40f);
    endtask
    task automatic t_regs();
        logic [7:0] ofs [6];
        int ld [6];
        ofs = '{OFS_ACC, OFS_EXT, OFS_BASE, OFS_LINK, OFS_MAINT, OFS_STOR};
        ld = '{14, 13, 10, 9, 8, 7};
        alu(CSEL_SWAP, BSEL_MAL, 6'h0c);
        for (int k = 0; k < 6; k++) begin
            st(ld[k]);
            rchk(ofs[k], 16'h8825);
        end
        st(11);
        rchk(OFS_EXT, 16'h104a);
        st(5);
        st(4);
        rchk(OFS_INDEX, 16'h8826);
        st(15);
        st(6);
        rchk(OFS_ACC, 16'h8826);
        rchk(OFS_STOR, 16'h8826);
        st(19);
        st(17);
        st(20);
        rchk(OFS_IP, 16'h2589);
        rchk(OFS_IPS, 16'h2588);
        cfg(4'h5, 16'h5a3c);
        st(16);
        rchk(OFS_CI, 16'h5a3c);
    endtask
    task automatic t_status();
        cfg(4'h1, 16'h4000);
        cfg(4'h2, 16'h4000);
        cfg(4'h0, 16'h2309);
        rchk(OFS_BUSC, 16'h8001);
        st(1);
        st(2);
        rchk(OFS_STATUS, 16'h3000);
        cfg(4'h1, 16'h8000);
        cfg(4'h2, 16'h8000);
        st(1);
        rchk(OFS_STATUS, 16'h2000);
        st(3);
        rchk(OFS_STATUS, 16'h6000);
        wr(OFS_AUX, 32'h0001_0005);
        wr(OFS_AUX, 32'h0002_0008);
        rchk(OFS_STATUS, 16'h7000);
    endtask
    task automatic t_protect();
        cfg(4'h1, 16'h0800);
        alu(CSEL_PASS, BSEL_MAL, 6'h2f);
        st(0);
        rchk(OFS_STATUS, 16'h7800);
        chk({31'h0, prot_ff}, 32'h1);
        irq_req <= 1'b1;
        repeat (8) @(posedge aclk);
        chk({31'h0, prot_ff}, 32'h0);
        irq_req <= 1'b0;
        viol_req <= 1'b1;
        repeat (8) @(posedge aclk);
        chk({31'h0, irq_ff}, 32'h1);
        viol_req <= 1'b0;
        rchk(OFS_STATUS, 16'h7c00);
        st(21);
        rd(OFS_STATUS);
        chk({31'h0, d[ST_AVIOL]}, 32'h0);
    endtask
    task automatic t_unmapped();
        rd(8'h38);
        chk(d, 32'h0);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        wr(8'h38, 32'h0000_ffff);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
    endtask
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, viol_req, irq_req} = 8'h00;
        {awaddr, araddr, wdata} = 48'h0;
        err_total = 0;
        compares = 0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_busc();
        t_regs();
        t_status();
        t_protect();
        t_unmapped();
        complete_run();
    end
    initial begin
        #600000;
        err_total++;
        complete_run();
    end
endmodule
`default_nettype wire
